// >>> design/acl_pkg.sv
// Purpose: shared constants and types of the audio config / link status register bank
// Assumes: registers indexed by word, byte address is four times the index
// Notes: widths of the audio packet fields are plain defaults
package acl_pkg;

  // ************************************************************
  // bus layout
  // ************************************************************
  localparam int ADR_W = 10;
  localparam int DAT_W = 32;
  localparam int IDX_W = 8;
  localparam logic [IDX_W-1:0] IDX_BRIDGE_AUDIO = 8'h54;
  localparam logic [IDX_W-1:0] IDX_AUDIO_CONFIG = 8'h55;
  localparam logic [IDX_W-1:0] IDX_LINK_STATUS = 8'h5a;
  localparam logic [IDX_W-1:0] IDX_LOW_FREQ_THRESHOLD = 8'h70;

  // ************************************************************
  // audio_config fields
  // ************************************************************
  localparam int AC_CONV_EN = 7;
  localparam int AC_PIN_OUT = 6;
  localparam int AC_FLUSH_TYPE = 3;
  localparam int AC_FLUSH_AIF = 2;
  localparam int AC_FLUSH_AVI = 1;
  localparam int AC_FLUSH_ACR = 0;
  localparam logic [7:0] AC_RW_MASK = 8'hcf;
  localparam logic [7:0] AC_RESET = 8'h0c;

  // ************************************************************
  // bridge audio select and threshold
  // ************************************************************
  localparam int BR_AUDIO_SRC = 1;
  localparam logic [7:0] BR_RW_MASK = 8'h02;
  localparam logic [7:0] BR_RESET = 8'h00;
  localparam logic [7:0] THRESH_RESET = 8'h10;

  // ************************************************************
  // link_and_input_status fields
  // ************************************************************
  localparam int ST_LINK_READY = 7;
  localparam int ST_TX_ACTIVE = 6;
  localparam int ST_PORT_HI = 5;
  localparam int ST_PORT_LO = 4;
  localparam int ST_DATA_RECOVERED = 3;
  localparam int ST_PLL_LOCK = 2;
  localparam int ST_CLK_ABSENT = 1;
  localparam int ST_FREQ_SETTLED = 0;
  localparam logic [7:0] ST_RESET = 8'h00;

  // ************************************************************
  // types and packet field widths
  // ************************************************************
  typedef enum logic [1:0] {
    PM_DUAL = 2'b00,
    PM_SINGLE0 = 2'b01,
    PM_SINGLE1 = 2'b10,
    PM_REPLICATE = 2'b11
  } acl_port_mode_t;

  typedef enum logic {
    SRC_INPUT_IF = 1'b0,
    SRC_LOCAL_PINS = 1'b1
  } acl_audio_src_t;

  localparam int TYPE_W = 4;
  localparam int CSUM_W = 8;
  localparam int ACR_W = 20;

endpackage

// >>> design/acl_flush_if.sv
// Purpose: carries audio packet fields and flush enables to the change detector
// Assumes: all signals on ref_clk
// Notes: flush is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface acl_flush_if;
  import acl_pkg::*;
  logic [TYPE_W-1:0] audioType;
  logic [CSUM_W-1:0] audioIfCsum;
  logic [CSUM_W-1:0] videoIfCsum;
  logic [ACR_W-1:0] acrN;
  logic [ACR_W-1:0] acrCts;
  logic [3:0] flushEn;
  logic flush;
  modport src (output audioType, audioIfCsum, videoIfCsum, acrN, acrCts, flushEn, input flush);
  modport det (input audioType, audioIfCsum, videoIfCsum, acrN, acrCts, flushEn, output flush);
endinterface
`default_nettype wire

// >>> design/acl_sync.sv
// Purpose: two flip-flop synchroniser bank
// Assumes: each bit is an independent level
// Notes: multi-bit words may skew by one cycle between bits
`timescale 1ns/1ps
`default_nettype none
module acl_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire

// >>> design/acl_flush_det.sv
// Purpose: raises a flush pulse when an enabled audio packet field changes
// Assumes: fields come from same-clock receiver logic
// Notes: the first value after reset only primes the history, it never flushes
`timescale 1ns/1ps
`default_nettype none
module acl_flush_det
  import acl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  acl_flush_if.det fl
);
  logic primed_r;
  logic [TYPE_W-1:0] typePrev_r;
  logic [CSUM_W-1:0] aifPrev_r;
  logic [CSUM_W-1:0] aviPrev_r;
  logic [ACR_W-1:0] nPrev_r;
  logic [ACR_W-1:0] ctsPrev_r;
  wire logic [3:0] changed;
  wire logic flushNxt;

  assign changed[AC_FLUSH_TYPE] = fl.audioType != typePrev_r;
  assign changed[AC_FLUSH_AIF] = fl.audioIfCsum != aifPrev_r;
  assign changed[AC_FLUSH_AVI] = fl.videoIfCsum != aviPrev_r;
  assign changed[AC_FLUSH_ACR] = (fl.acrN != nPrev_r) || (fl.acrCts != ctsPrev_r);
  assign flushNxt = primed_r && |(changed & fl.flushEn); // R4 R5 R6 R7

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      primed_r <= 1'b0;
      typePrev_r <= '0;
      aifPrev_r <= '0;
      aviPrev_r <= '0;
      nPrev_r <= '0;
      ctsPrev_r <= '0;
      fl.flush <= 1'b0;
    end
    else
    begin
      primed_r <= 1'b1;
      typePrev_r <= fl.audioType;
      aifPrev_r <= fl.audioIfCsum;
      aviPrev_r <= fl.videoIfCsum;
      nPrev_r <= fl.acrN;
      ctsPrev_r <= fl.acrCts;
      fl.flush <= flushNxt;
    end
  end
endmodule
`default_nettype wire

// >>> design/acl_regs_top.sv
// Purpose: audio configuration and link / input status registers behind classic Wishbone
// Assumes: status levels arrive from other domains; audio packet fields and receiver audio are on ref_clk
// Notes: one byte per register in data bits 7:0, byte lane 0 only
//
// Overview of operation
// R1 - conversion bit enables converter, selects its clock
// R2 - pin output bit drives input audio out
// R3 - pin output ignored unless input-interface source
// R4 - flush received-audio FIFO on type change
// R5 - flush FIFO on audio infoframe checksum change
// R6 - flush FIFO on video infoframe checksum change
// R7 - flush FIFO on N or CTS change
// R8 - link ready after downstream detect and capabilities
// R9 - transmit status needs active transmitter, locked receiver
// R10 - transmit status waits for input and mode
// R11 - port mode field encodes dual/single/replicate
// R12 - data recovered bit follows input receiver
// R13 - PLL lock bit follows input PLL
// R14 - clock absent below low frequency threshold
// R15 - frequency settled bit follows detector
// R16 - audio source selects input or local pins
// R17 - read-only and reserved writes ignored, read zero
`timescale 1ns/1ps
`default_nettype none
module acl_regs_top
  import acl_pkg::*;
#(
  parameter int AUDIO_W = 4,
  parameter logic [7:0] THRESH_DEFAULT = THRESH_RESET
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [DAT_W-1:0] wb_dat_i,
  output logic [DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // status levels from link, receiver and frequency detector
  input wire logic linkDetectedIn,
  input wire logic linkCapsKnownIn,
  input wire logic txActiveIn,
  input wire logic remoteLockedIn,
  input wire logic validInputIn,
  input wire logic modeEnteredIn,
  input wire logic [1:0] portModeIn,
  input wire logic dataRecoveredIn,
  input wire logic pllLockIn,
  input wire logic clkAbsentIn,
  input wire logic freqSettledIn,
  // audio
  input wire logic [AUDIO_W-1:0] rxAudio,
  input wire logic [AUDIO_W-1:0] i2sPinIn,
  output logic [AUDIO_W-1:0] i2sPinOut,
  output logic i2sPinOe,
  output logic [AUDIO_W-1:0] downstreamAudio,
  output logic downstreamAudioSel,
  output logic tdmConvEn,
  output logic convClkSel,
  // received-audio packet fields
  input wire logic [TYPE_W-1:0] audioType,
  input wire logic [CSUM_W-1:0] audioIfCsum,
  input wire logic [CSUM_W-1:0] videoIfCsum,
  input wire logic [ACR_W-1:0] acrN,
  input wire logic [ACR_W-1:0] acrCts,
  output logic fifoFlush,
  output logic [7:0] lowFreqThreshold
);

  // ************************************************************
  // index decode
  // ************************************************************
  // misaligned byte addresses never hit, so they read zero
  function automatic logic idxHit(input logic [ADR_W-1:0] adr, input logic [IDX_W-1:0] idx);
    idxHit = (adr[1:0] == 2'b00) && (adr[ADR_W-1:2] == idx);
  endfunction

  logic [7:0] audioCfg_r;
  logic [7:0] bridgeAudio_r;
  logic [7:0] thresh_r;
  logic [7:0] status_r;
  logic ack_r;
  logic [DAT_W-1:0] rdData_r;

  wire logic busReq;
  wire logic wrStrobe;
  wire logic hitAudio;
  wire logic hitBridge;
  wire logic hitStatus;
  wire logic hitThresh;
  wire logic [7:0] rdByte;

  assign busReq = wb_cyc_i && wb_stb_i && !ack_r;
  // a write lands on the edge at which the master sees ack, never before the cycle ends
  assign wrStrobe = wb_cyc_i && wb_stb_i && ack_r && wb_we_i && wb_sel_i[0];
  assign hitAudio = idxHit(wb_adr_i, IDX_AUDIO_CONFIG);
  assign hitBridge = idxHit(wb_adr_i, IDX_BRIDGE_AUDIO);
  assign hitStatus = idxHit(wb_adr_i, IDX_LINK_STATUS);
  assign hitThresh = idxHit(wb_adr_i, IDX_LOW_FREQ_THRESHOLD);

  // unmapped words still ack, reading zero, so a stray access never hangs the bus
  assign rdByte = hitAudio ? audioCfg_r :
                  hitBridge ? bridgeAudio_r :
                  hitStatus ? status_r :
                  hitThresh ? thresh_r : 8'h00;

  // ************************************************************
  // register writes
  // ************************************************************
  wire logic [7:0] audioCfgNxt;
  wire logic [7:0] bridgeAudioNxt;
  wire logic [7:0] threshNxt;

  assign audioCfgNxt = (wrStrobe && hitAudio) ? (wb_dat_i[7:0] & AC_RW_MASK) : audioCfg_r; // R17
  assign bridgeAudioNxt = (wrStrobe && hitBridge) ? (wb_dat_i[7:0] & BR_RW_MASK) : bridgeAudio_r; // R17
  assign threshNxt = (wrStrobe && hitThresh) ? wb_dat_i[7:0] : thresh_r;

  // status index has no write path at all
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      audioCfg_r <= AC_RESET;
    else
      audioCfg_r <= audioCfgNxt;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      bridgeAudio_r <= BR_RESET;
    else
      bridgeAudio_r <= bridgeAudioNxt;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      thresh_r <= THRESH_DEFAULT;
    else
      thresh_r <= threshNxt;
  end

  // ************************************************************
  // bus answer
  // ************************************************************
  // one wait state: ack drops after one cycle even if the strobe stays up
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      ack_r <= 1'b0;
    else
      ack_r <= busReq;
  end

  // data bus reads zero outside ack so a late sample never sees stale data
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      rdData_r <= '0;
    else
      rdData_r <= busReq ? {24'h000000, rdByte} : '0;
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdData_r;

  // ************************************************************
  // status capture
  // ************************************************************
  // positions in the synchronised status vector
  localparam int NSYNC = 12;
  localparam int SY_LINK_DET = 11;
  localparam int SY_LINK_CAPS = 10;
  localparam int SY_TX_ACTIVE = 9;
  localparam int SY_REMOTE_LOCK = 8;
  localparam int SY_VALID_INPUT = 7;
  localparam int SY_MODE_ENTERED = 6;
  localparam int SY_PORT_HI = 5;
  localparam int SY_PORT_LO = 4;
  localparam int SY_DATA_REC = 3;
  localparam int SY_PLL_LOCK = 2;
  localparam int SY_CLK_ABSENT = 1;
  localparam int SY_FREQ_SET = 0;
  wire logic [NSYNC-1:0] stRaw;
  wire logic [NSYNC-1:0] stSync;

  // each bit resyncs alone; the two port-mode bits may skew by a cycle while they change
  assign stRaw[SY_LINK_DET] = linkDetectedIn;
  assign stRaw[SY_LINK_CAPS] = linkCapsKnownIn;
  assign stRaw[SY_TX_ACTIVE] = txActiveIn;
  assign stRaw[SY_REMOTE_LOCK] = remoteLockedIn;
  assign stRaw[SY_VALID_INPUT] = validInputIn;
  assign stRaw[SY_MODE_ENTERED] = modeEnteredIn;
  assign stRaw[SY_PORT_HI:SY_PORT_LO] = portModeIn;
  assign stRaw[SY_DATA_REC] = dataRecoveredIn;
  assign stRaw[SY_PLL_LOCK] = pllLockIn;
  assign stRaw[SY_CLK_ABSENT] = clkAbsentIn;
  assign stRaw[SY_FREQ_SET] = freqSettledIn;

  acl_sync #(.W(NSYNC)) u_stat_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .d(stRaw),
    .q(stSync)
  );

  wire logic linkReady;
  wire logic txStatus;
  acl_port_mode_t portMode;
  wire logic [7:0] statusNxt;

  assign linkReady = stSync[SY_LINK_DET] && stSync[SY_LINK_CAPS]; // R8
  assign txStatus = stSync[SY_TX_ACTIVE] && stSync[SY_REMOTE_LOCK] // R9
                    && stSync[SY_VALID_INPUT] && stSync[SY_MODE_ENTERED]; // R10
  // field only meaningful with transmit status; held at dual code otherwise
  assign portMode = txStatus ? acl_port_mode_t'(stSync[SY_PORT_HI:SY_PORT_LO]) : PM_DUAL; // R11

  // whole byte is re-registered each cycle; software sees at most three cycles of lag
  assign statusNxt[ST_LINK_READY] = linkReady; // R8
  assign statusNxt[ST_TX_ACTIVE] = txStatus; // R9
  assign statusNxt[ST_PORT_HI:ST_PORT_LO] = portMode; // R11
  assign statusNxt[ST_DATA_RECOVERED] = stSync[SY_DATA_REC]; // R12
  assign statusNxt[ST_PLL_LOCK] = stSync[SY_PLL_LOCK]; // R13
  assign statusNxt[ST_CLK_ABSENT] = stSync[SY_CLK_ABSENT]; // R14
  assign statusNxt[ST_FREQ_SETTLED] = stSync[SY_FREQ_SET]; // R15

  // read-only: no bus path reaches this flop
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      status_r <= ST_RESET;
    else
      status_r <= statusNxt;
  end

  // ************************************************************
  // audio routing
  // ************************************************************
  wire logic [AUDIO_W-1:0] localAudio;
  acl_audio_src_t audioSrc;
  wire logic pinDriveNxt;
  wire logic [AUDIO_W-1:0] downNxt;

  acl_sync #(.W(AUDIO_W)) u_pin_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .d(i2sPinIn),
    .q(localAudio)
  );

  assign audioSrc = acl_audio_src_t'(bridgeAudio_r[BR_AUDIO_SRC]); // R16
  assign pinDriveNxt = audioCfg_r[AC_PIN_OUT] && (audioSrc == SRC_INPUT_IF); // R2 R3
  assign downNxt = (audioSrc == SRC_LOCAL_PINS) ? localAudio : rxAudio; // R16

  // pins carry zero while released so no stale sample shows when drive returns
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      i2sPinOe <= 1'b0;
      i2sPinOut <= '0;
    end
    else
    begin
      i2sPinOe <= pinDriveNxt; // R2 R3
      i2sPinOut <= pinDriveNxt ? rxAudio : '0; // R2
    end
  end

  // local pins pass the synchroniser, so that path lags the receiver path by two cycles
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      downstreamAudio <= '0;
      downstreamAudioSel <= 1'b0;
    end
    else
    begin
      downstreamAudio <= downNxt; // R16
      downstreamAudioSel <= bridgeAudio_r[BR_AUDIO_SRC]; // R16
    end
  end

  // ************************************************************
  // converter control and threshold export
  // ************************************************************
  // enable and clock select move together so the converter never runs on the wrong clock
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      tdmConvEn <= 1'b0;
      convClkSel <= 1'b0;
    end
    else
    begin
      tdmConvEn <= audioCfg_r[AC_CONV_EN]; // R1
      convClkSel <= audioCfg_r[AC_CONV_EN]; // R1
    end
  end

  // comparison itself lives in the frequency detector; only the level leaves here
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      lowFreqThreshold <= THRESH_DEFAULT;
    else
      lowFreqThreshold <= thresh_r; // R14
  end

  // ************************************************************
  // audio FIFO flush on packet change
  // ************************************************************
  // fields are on the receiver clock already, so they skip the synchroniser
  acl_flush_if flushBus ();

  assign flushBus.audioType = audioType;
  assign flushBus.audioIfCsum = audioIfCsum;
  assign flushBus.videoIfCsum = videoIfCsum;
  assign flushBus.acrN = acrN;
  assign flushBus.acrCts = acrCts;
  assign flushBus.flushEn = audioCfg_r[3:0]; // R4 R5 R6 R7

  acl_flush_det u_flush (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .fl(flushBus)
  );

  // second stage keeps the pulse straight from a flop at the port
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      fifoFlush <= 1'b0;
    else
      fifoFlush <= flushBus.flush;
  end

endmodule
`default_nettype wire

// >>> verification/acl_regs_chk.sv
// Purpose: port-level assertions for the audio config / link status bank
// Assumes: one clock, synchronous active-low reset
// Notes: status latency is judged by the bench, not here
`timescale 1ns/1ps
`default_nettype none
module acl_regs_chk
  import acl_pkg::*;
#(
  parameter int AUDIO_W = 4
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [DAT_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [AUDIO_W-1:0] rxAudio,
  input wire logic [AUDIO_W-1:0] i2sPinOut,
  input wire logic i2sPinOe,
  input wire logic [AUDIO_W-1:0] downstreamAudio,
  input wire logic downstreamAudioSel,
  input wire logic tdmConvEn,
  input wire logic convClkSel,
  input wire logic [TYPE_W-1:0] audioType,
  input wire logic [CSUM_W-1:0] audioIfCsum,
  input wire logic [CSUM_W-1:0] videoIfCsum,
  input wire logic [ACR_W-1:0] acrN,
  input wire logic [ACR_W-1:0] acrCts,
  input wire logic fifoFlush
);
  // ************************************************************
  // helpers
  // ************************************************************
  wire logic [TYPE_W+2*CSUM_W+2*ACR_W-1:0] fld;
  wire logic cfgRd;
  wire logic stRd;
  assign fld = {audioType, audioIfCsum, videoIfCsum, acrN, acrCts};
  assign cfgRd = wb_ack_o && !wb_we_i && wb_adr_i == {IDX_AUDIO_CONFIG, 2'b00};
  assign stRd = wb_ack_o && !wb_we_i && wb_adr_i == {IDX_LINK_STATUS, 2'b00};
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  chk_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == '0) else $error("read data outside ack");
  chk_rsvd_zero: assert property (cfgRd |-> wb_dat_o[DAT_W-1:8] == '0 && wb_dat_o[5:4] == 2'b00)
    else $error("reserved bits not zero");
  chk_port_idle: assert property (stRd && !wb_dat_o[ST_TX_ACTIVE] |-> wb_dat_o[5:4] == 2'b00)
    else $error("port mode without transmit");
  chk_conv_clk: assert property (tdmConvEn == convClkSel) else $error("converter clock mismatch");
  chk_pin_src: assert property (i2sPinOe |-> !downstreamAudioSel) else $error("pins driven, local source");
  chk_pin_data: assert property (i2sPinOe && $past(i2sPinOe) |-> i2sPinOut == $past(rxAudio))
    else $error("pin audio wrong");
  chk_down_input: assert property (!downstreamAudioSel && !$past(downstreamAudioSel) && $past(rst_b)
    |-> downstreamAudio == $past(rxAudio)) else $error("downstream audio wrong");
  chk_flush_cause: assert property (fifoFlush |-> $past(fld, 2) != $past(fld, 3))
    else $error("flush without change");

  cov_write: cover property (wb_ack_o && wb_we_i);
  cov_flush: cover property (fifoFlush);
  cov_pins: cover property (i2sPinOe ##1 !i2sPinOe);
endmodule
bind acl_regs_top acl_regs_chk #(.AUDIO_W(AUDIO_W)) chkI (
  .ref_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
  .rxAudio, .i2sPinOut, .i2sPinOe, .downstreamAudio, .downstreamAudioSel, .tdmConvEn,
  .convClkSel, .audioType, .audioIfCsum, .videoIfCsum, .acrN, .acrCts, .fifoFlush
);
`default_nettype wire

// >>> verification/acl_regs_top_tb.sv
// Purpose: self-checking bench for the audio config / link status bank
// Assumes: inputs change by non-blocking assignment at ref_clk rising edges
// Notes: bus answers are taken at the rising edge that shows ack; lowFreqThreshold at the rising edge ending a read; other outputs at the falling edge
`timescale 1ns/1ps
`default_nettype none
module acl_regs_top_tb
  import acl_pkg::*;
;
  localparam logic [ADR_W-1:0] A_CFG = {IDX_AUDIO_CONFIG, 2'b00};
  localparam logic [ADR_W-1:0] A_BR = {IDX_BRIDGE_AUDIO, 2'b00};
  localparam logic [ADR_W-1:0] A_ST = {IDX_LINK_STATUS, 2'b00};
  localparam logic [ADR_W-1:0] A_TH = {IDX_LOW_FREQ_THRESHOLD, 2'b00};
  // status inputs in status-bit order, port mode at 5:4
  localparam logic [11:0] SV [15] = '{12'hc00, 12'h800, 12'h400, 12'h3e0, 12'h3c0, 12'h3d0, 12'h3f0,
    12'h1e0, 12'h2e0, 12'h360, 12'h3a0, 12'h008, 12'h004, 12'h002, 12'h001};
  localparam logic [7:0] SE [15] = '{8'h80, 8'h00, 8'h00, 8'h60, 8'h40, 8'h50, 8'h70,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h04, 8'h02, 8'h01};
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [ADR_W-1:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [DAT_W-1:0] wb_dat_i = '0;
  logic [11:0] stIn = '0;
  logic [3:0] rxAudio = 4'h0;
  logic [3:0] i2sPinIn = 4'h0;
  logic [TYPE_W-1:0] audioType = '0;
  logic [CSUM_W-1:0] audioIfCsum = '0;
  logic [CSUM_W-1:0] videoIfCsum = '0;
  logic [ACR_W-1:0] acrN = '0;
  logic [ACR_W-1:0] acrCts = '0;
  wire logic [DAT_W-1:0] wb_dat_o;
  wire logic wb_ack_o, i2sPinOe, downstreamAudioSel, tdmConvEn, convClkSel, fifoFlush;
  wire logic [3:0] i2sPinOut, downstreamAudio;
  wire logic [7:0] lowFreqThreshold;
  wire logic [7:0] outs;
  int nErrors = 0;
  int samplesChecked = 0;
  int cycles = 0;
  assign outs = {tdmConvEn, convClkSel, i2sPinOe, downstreamAudioSel, i2sPinOut};

  acl_regs_top DUT (
    .ref_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .linkDetectedIn(stIn[11]), .linkCapsKnownIn(stIn[10]), .txActiveIn(stIn[9]), .remoteLockedIn(stIn[8]),
    .validInputIn(stIn[7]), .modeEnteredIn(stIn[6]), .portModeIn(stIn[5:4]), .dataRecoveredIn(stIn[3]),
    .pllLockIn(stIn[2]), .clkAbsentIn(stIn[1]), .freqSettledIn(stIn[0]), .rxAudio, .i2sPinIn, .i2sPinOut,
    .i2sPinOe, .downstreamAudio, .downstreamAudioSel, .tdmConvEn, .convClkSel, .audioType, .audioIfCsum,
    .videoIfCsum, .acrN, .acrCts, .fifoFlush, .lowFreqThreshold
  );

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic endOfTest();
    if (nErrors == 0 && samplesChecked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // entered just after a rising edge; hang is cut by the cycle ceiling
  task automatic wb(input logic we, input logic [ADR_W-1:0] adr, input logic [7:0] d, output logic [7:0] q);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h0, d};
    @(posedge ref_clk);
    while (wb_ack_o !== 1'b1)
      @(posedge ref_clk);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [ADR_W-1:0] adr, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, adr, d, q);
  endtask
  task automatic rdc(input logic [ADR_W-1:0] adr, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, adr, 8'h00, q);
    check(q, e);
  endtask
  task automatic see(input logic [7:0] eOut, input logic [3:0] eDown);
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    check(outs, eOut);
    check({4'h0, downstreamAudio}, {4'h0, eDown});
    @(posedge ref_clk);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic tReset();
    rdc(A_CFG, 8'h0c);
    rdc(A_ST, 8'h00);
    rdc(A_BR, 8'h00);
    rdc(A_TH, 8'h10);
    check(lowFreqThreshold, 8'h10);
    rdc(10'h3fc, 8'h00);
  endtask
  task automatic tCfg();
    rxAudio <= 4'ha;
    i2sPinIn <= 4'h5;
    wr(A_CFG, 8'hff);
    rdc(A_CFG, 8'hcf);
    see(8'hea, 4'ha);
    wr(A_BR, 8'h02);
    rdc(A_BR, 8'h02);
    see(8'hd0, 4'h5);
    wb_sel_i <= 4'he;
    wr(A_CFG, 8'h00);
    wb_sel_i <= 4'hf;
    rdc(A_CFG, 8'hcf);
    wr(A_BR, 8'h00);
    wr(A_CFG, 8'h00);
    see(8'h00, 4'ha);
    wr(A_TH, 8'h37);
    rdc(A_TH, 8'h37);
    check(lowFreqThreshold, 8'h37);
  endtask
  task automatic tStatus();
    for (int i = 0; i < 15; i++)
    begin
      stIn <= SV[i];
      repeat (4) @(posedge ref_clk);
      rdc(A_ST, SE[i]);
    end
    wr(A_ST, 8'hff);
    rdc(A_ST, 8'h01);
  endtask
  // each field once with its enable set, once with all enables clear
  task automatic tFlush();
    int n;
    int b;
    for (int i = 0; i < 5; i++)
      for (int en = 1; en >= 0; en--)
      begin
        b = (i == 4) ? 0 : i;
        wr(A_CFG, en ? 8'(1 << b) : 8'h00);
        case (i)
          0: acrN <= acrN + 1'b1;
          1: videoIfCsum <= videoIfCsum + 1'b1;
          2: audioIfCsum <= audioIfCsum + 1'b1;
          3: audioType <= audioType + 1'b1;
          default: acrCts <= acrCts + 1'b1;
        endcase
        n = 0;
        repeat (5)
        begin
          @(negedge ref_clk);
          n += (fifoFlush === 1'b1);
        end
        @(posedge ref_clk);
        check(8'(n), 8'(en));
      end
  endtask

  always #5 ref_clk = ~ref_clk;
  // whole run needs well under a thousand cycles
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      nErrors++;
      endOfTest();
    end
  end
  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    tReset();
    tCfg();
    tStatus();
    tFlush();
    endOfTest();
  end
endmodule
`default_nettype wire
